// ### design/swhd_defines.svh
// Constants for the sleep, wake and host-detect controller
`ifndef SWHD_DEFINES_SVH
`define SWHD_DEFINES_SVH

// Clock rates
`define SWHD_CLK_HZ     40000000
`define SWHD_LF_HZ      32768
`define SWHD_LF_RATIO   (`SWHD_CLK_HZ / `SWHD_LF_HZ)

// Widths
`define SWHD_TMR_W      16
`define SWHD_SYNC_W     7
`define SWHD_CAUSE_W    6
`define SWHD_BLK_W      4

// Synchroniser lanes
`define SWHD_S_GPIO     0
`define SWHD_S_COMP     1
`define SWHD_S_RTC      2
`define SWHD_S_WDT      3
`define SWHD_S_VBUS     4
`define SWHD_S_FLAV     5
`define SWHD_S_LF       6

// Wake cause bits
`define SWHD_C_TMR      0
`define SWHD_C_GPIO     1
`define SWHD_C_COMP     2
`define SWHD_C_RTC      3
`define SWHD_C_WDT      4
`define SWHD_C_HOST     5

`endif

// ### design/swhd_pkg.sv
// Types for the sleep, wake and host-detect controller
`include "swhd_defines.svh"

package swhd_pkg;

    // Power state of the device
    typedef enum logic [1:0] {
        SWHD_ACTIVE,
        SWHD_LIGHT,
        SWHD_LSERVE,
        SWHD_DEEP
    } swhd_mode_type;

    // Host interface found at power-up
    typedef enum logic [2:0] {
        SWHD_IF_NONE,
        SWHD_IF_SDIO,
        SWHD_IF_SPI,
        SWHD_IF_UART,
        SWHD_IF_USB,
        SWHD_IF_USB_CDC
    } swhd_host_if_type;

    // Firmware control bits
    typedef struct packed {
        logic                        light_req;
        logic                        deep_req;
        logic                        ram_retain;
        logic                        gpio_pol;
        logic                        periodic_en;
        logic [`SWHD_CAUSE_W-1:0]    cause_clr;
        logic [`SWHD_TMR_W-1:0]      timeout;
    } swhd_cmd_type;

    // Status seen by firmware and the rest of the chip
    typedef struct packed {
        swhd_mode_type               mode;
        logic                        hf_clk_en;
        logic                        subsys_run;
        logic                        ram_retain_en;
        logic                        host_ready;
        swhd_host_if_type            host_if;
        logic                        host_if_valid;
        logic [`SWHD_CAUSE_W-1:0]    wake_cause;
        logic                        deep_refused;
        logic [`SWHD_BLK_W-1:0]      blk_clk_en;
    } swhd_stat_type;

    // Whole state of the controller
    typedef struct packed {
        logic [`SWHD_SYNC_W-1:0]     sync1;
        logic [`SWHD_SYNC_W-1:0]     sync2;
        logic                        lf_prev;
        logic [`SWHD_TMR_W-1:0]      tmr;
        swhd_mode_type               mode;
        swhd_host_if_type            host_if;
        logic                        host_if_valid;
        logic                        ram_retain;
        logic [`SWHD_CAUSE_W-1:0]    cause;
        logic                        deep_refused;
        logic [`SWHD_BLK_W-1:0]      blk_en;
    } swhd_state_type;

endpackage : swhd_pkg

// ### design/swhd_sleep_ctrl.sv
// Sleep and wake controller with host interface detection
//
// Contract
// - Deep sleep manager owns all subsystem run states
// - Deep sleep logic advances only on 32 kHz; here only the timer does, wake checks run every clk cycle
// - Deep sleep exits after programmed timeout
// - Deep sleep exits on GPIO at polarity
// - Deep sleep exits on comparator event
// - Deep sleep exits on RTC timer timeout
// - Deep sleep exits on watchdog interrupt
// - No deep sleep while host is USB
// - Deep sleep keeps timer, optional RAM retention
// - Light sleep gates high-frequency clocks, keeps state
// - Host interface stays ready in light sleep
// - Host command ungates clocks, re-gate when done
// - Light sleep exits on GPIO
// - Light sleep exits after programmed timeout
// - Gate unused blocks, enter light or deep
// - Standby wakes itself periodically without host
// - SDIO or SPI detected from host packets
// - USB detected from VBUS level
// - USB flavour chosen from selection pin
// - Detected interface latched, reused every wake

`include "swhd_defines.svh"

module swhd_sleep_ctrl (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  swhd_pkg::swhd_cmd_type       cmd,
    input  wire logic                    host_cmd,
    input  wire logic                    host_op_done,
    input  wire logic                    sdio_pkt,
    input  wire logic                    spi_pkt,
    input  wire logic                    uart_sw_detect,
    input  wire logic [`SWHD_BLK_W-1:0]  blk_busy,
    input  wire logic                    wake_gpio_pin,
    input  wire logic                    comparator_evt,
    input  wire logic                    rtc_timeout_evt,
    input  wire logic                    wdt_irq,
    input  wire logic                    vbus_pin,
    input  wire logic                    usb_flavour_select_pin,
    input  wire logic                    lf_clk_pin,
    output swhd_pkg::swhd_stat_type      stat
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // True for either USB flavour
    function automatic logic is_usb(input swhd_pkg::swhd_host_if_type hif);
        is_usb = (hif == swhd_pkg::SWHD_IF_USB) || (hif == swhd_pkg::SWHD_IF_USB_CDC);
    endfunction : is_usb

    swhd_pkg::swhd_state_type   q;
    swhd_pkg::swhd_state_type   d;
    logic                       lf_tick;
    logic                       gpio_hit;
    logic                       tmr_done;
    logic [`SWHD_CAUSE_W-1:0]   cause_set;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Wake qualification: pins from second synchroniser stage only, timeout from the timer
    always_comb begin
        lf_tick  = q.sync2[`SWHD_S_LF] & ~q.lf_prev;
        gpio_hit = (q.sync2[`SWHD_S_GPIO] == cmd.gpio_pol);
        tmr_done = (q.tmr >= cmd.timeout);
    end

    // State machine, timer, detection and cause capture
    always_comb begin
        d           = q;
        cause_set   = '0;
        d.sync1     = {lf_clk_pin, usb_flavour_select_pin, vbus_pin, wdt_irq,
                       rtc_timeout_evt, comparator_evt, wake_gpio_pin};
        d.sync2     = q.sync1;
        d.lf_prev   = q.sync2[`SWHD_S_LF];
        d.deep_refused = 1'b0;
        // Sleep timer counts 32 kHz ticks only
        if (lf_tick && (q.mode == swhd_pkg::SWHD_LIGHT || q.mode == swhd_pkg::SWHD_DEEP)
            && !tmr_done) begin
            d.tmr = q.tmr + `SWHD_TMR_W'(1);
        end
        unique case (q.mode)
            swhd_pkg::SWHD_ACTIVE: begin
                d.tmr = '0;
                if (cmd.deep_req) begin
                    if (is_usb(q.host_if)) begin
                        d.deep_refused = 1'b1;
                    end else begin
                        d.mode       = swhd_pkg::SWHD_DEEP;
                        d.ram_retain = cmd.ram_retain;
                    end
                end else if (cmd.light_req) begin
                    d.mode = swhd_pkg::SWHD_LIGHT;
                end
            end
            swhd_pkg::SWHD_LIGHT: begin
                if (host_cmd) begin
                    d.mode = swhd_pkg::SWHD_LSERVE;
                    cause_set[`SWHD_C_HOST] = 1'b1;
                end else if (gpio_hit) begin
                    d.mode = swhd_pkg::SWHD_ACTIVE;
                    cause_set[`SWHD_C_GPIO] = 1'b1;
                end else if (tmr_done) begin
                    cause_set[`SWHD_C_TMR] = 1'b1;
                    d.tmr  = '0;
                    d.mode = cmd.periodic_en ? swhd_pkg::SWHD_LSERVE
                                             : swhd_pkg::SWHD_ACTIVE;
                end
            end
            swhd_pkg::SWHD_LSERVE: begin
                if (host_op_done) begin
                    d.mode = swhd_pkg::SWHD_LIGHT;
                    d.tmr  = '0;
                end
            end
            swhd_pkg::SWHD_DEEP: begin
                cause_set[`SWHD_C_TMR]  = tmr_done;
                cause_set[`SWHD_C_GPIO] = gpio_hit;
                cause_set[`SWHD_C_COMP] = q.sync2[`SWHD_S_COMP];
                cause_set[`SWHD_C_RTC]  = q.sync2[`SWHD_S_RTC];
                cause_set[`SWHD_C_WDT]  = q.sync2[`SWHD_S_WDT];
                if (|cause_set) begin
                    d.mode       = swhd_pkg::SWHD_ACTIVE;
                    d.ram_retain = 1'b0;
                end
            end
        endcase
        // Set wins over clear
        d.cause = (q.cause & ~cmd.cause_clr) | cause_set;
        // One-time host detection after power-up, kept across wakes
        if (!q.host_if_valid && q.mode == swhd_pkg::SWHD_ACTIVE) begin
            if (q.sync2[`SWHD_S_VBUS]) begin
                d.host_if = q.sync2[`SWHD_S_FLAV] ? swhd_pkg::SWHD_IF_USB
                                                  : swhd_pkg::SWHD_IF_USB_CDC;
                d.host_if_valid = 1'b1;
            end else if (sdio_pkt) begin
                d.host_if       = swhd_pkg::SWHD_IF_SDIO;
                d.host_if_valid = 1'b1;
            end else if (spi_pkt) begin
                d.host_if       = swhd_pkg::SWHD_IF_SPI;
                d.host_if_valid = 1'b1;
            end else if (uart_sw_detect) begin
                d.host_if       = swhd_pkg::SWHD_IF_UART;
                d.host_if_valid = 1'b1;
            end
        end
        // Clock only the blocks that report work while clocks run
        d.blk_en = (d.mode == swhd_pkg::SWHD_ACTIVE || d.mode == swhd_pkg::SWHD_LSERVE)
                   ? blk_busy : '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    // Synchronous active-low reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            q <= '{sync1: '0, sync2: '0, lf_prev: 1'b0, tmr: '0,
                   mode: swhd_pkg::SWHD_ACTIVE, host_if: swhd_pkg::SWHD_IF_NONE,
                   host_if_valid: 1'b0, ram_retain: 1'b0, cause: '0,
                   deep_refused: 1'b0, blk_en: '0};
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Decoded from the state flops
    always_comb begin
        stat.mode          = q.mode;
        stat.hf_clk_en     = (q.mode == swhd_pkg::SWHD_ACTIVE)
                             || (q.mode == swhd_pkg::SWHD_LSERVE);
        stat.subsys_run    = (q.mode != swhd_pkg::SWHD_DEEP);
        stat.ram_retain_en = q.ram_retain;
        stat.host_ready    = (q.mode != swhd_pkg::SWHD_DEEP);
        stat.host_if       = q.host_if;
        stat.host_if_valid = q.host_if_valid;
        stat.wake_cause    = q.cause;
        stat.deep_refused  = q.deep_refused;
        stat.blk_clk_en    = q.blk_en;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    usb_no_deep_a: assert property (
        q.mode == swhd_pkg::SWHD_ACTIVE && cmd.deep_req && is_usb(q.host_if)
        |=> q.mode == swhd_pkg::SWHD_ACTIVE && stat.deep_refused)
        else $error("deep sleep entered with USB host");

    light_gated_a: assert property (
        q.mode == swhd_pkg::SWHD_LIGHT |-> !stat.hf_clk_en && stat.blk_clk_en == '0)
        else $error("clocks running in light sleep");

    deep_owned_a: assert property (
        $rose(q.mode == swhd_pkg::SWHD_DEEP) |-> !stat.subsys_run && !stat.hf_clk_en)
        else $error("subsystem running in deep sleep");

    host_serve_a: assert property (
        q.mode == swhd_pkg::SWHD_LIGHT && host_cmd
        |=> stat.hf_clk_en && stat.wake_cause[`SWHD_C_HOST])
        else $error("host command not served");

    regate_done_a: assert property (
        q.mode == swhd_pkg::SWHD_LSERVE && host_op_done
        |=> q.mode == swhd_pkg::SWHD_LIGHT ##0 !stat.hf_clk_en)
        else $error("clock not regated after operation");

    deep_comp_a: assert property (
        q.mode == swhd_pkg::SWHD_DEEP && q.sync2[`SWHD_S_COMP]
        |=> q.mode == swhd_pkg::SWHD_ACTIVE && q.cause[`SWHD_C_COMP])
        else $error("comparator did not wake");

    deep_wdt_a: assert property (
        q.mode == swhd_pkg::SWHD_DEEP && $past(wdt_irq, 2)
        |=> q.cause[`SWHD_C_WDT] && q.mode == swhd_pkg::SWHD_ACTIVE)
        else $error("watchdog did not wake");

    deep_tmr_a: assert property (
        q.mode == swhd_pkg::SWHD_DEEP && !lf_tick |=> $stable(q.tmr))
        else $error("deep timer moved without slow tick");

    deep_timeout_a: assert property (
        q.mode == swhd_pkg::SWHD_DEEP && q.tmr >= cmd.timeout
        |=> q.mode == swhd_pkg::SWHD_ACTIVE)
        else $error("deep timeout did not wake");

    host_kept_a: assert property (
        q.host_if_valid |=> q.host_if_valid && $stable(q.host_if))
        else $error("host interface redetected");

    cause_sticky_a: assert property (
        q.cause[`SWHD_C_GPIO] && !cmd.cause_clr[`SWHD_C_GPIO] |=> q.cause[`SWHD_C_GPIO])
        else $error("wake cause lost");

    // Pin wakes are judged on the pin two edges back, past both flops
    deep_gpio_a: assert property (
        q.mode == swhd_pkg::SWHD_DEEP && $past(wake_gpio_pin, 2) == cmd.gpio_pol
        |=> q.mode == swhd_pkg::SWHD_ACTIVE && q.cause[`SWHD_C_GPIO])
        else $error("gpio did not wake from deep sleep");

    deep_rtc_a: assert property (
        q.mode == swhd_pkg::SWHD_DEEP && $past(rtc_timeout_evt, 2)
        |=> q.mode == swhd_pkg::SWHD_ACTIVE && q.cause[`SWHD_C_RTC])
        else $error("rtc timer did not wake");

    deep_retain_a: assert property (
        q.mode == swhd_pkg::SWHD_ACTIVE && cmd.deep_req && !is_usb(q.host_if)
        |=> q.mode == swhd_pkg::SWHD_DEEP && stat.ram_retain_en == $past(cmd.ram_retain))
        else $error("retention variant not captured");

    deep_quiet_a: assert property (
        q.mode == swhd_pkg::SWHD_DEEP |-> !stat.hf_clk_en && stat.blk_clk_en == '0)
        else $error("clocks running in deep sleep");

    light_ready_a: assert property (
        q.mode == swhd_pkg::SWHD_LIGHT |-> stat.host_ready && stat.subsys_run)
        else $error("host interface not ready in light sleep");

    light_gpio_a: assert property (
        q.mode == swhd_pkg::SWHD_LIGHT && !host_cmd
        && $past(wake_gpio_pin, 2) == cmd.gpio_pol
        |=> q.mode == swhd_pkg::SWHD_ACTIVE && q.cause[`SWHD_C_GPIO])
        else $error("gpio did not wake from light sleep");

    light_timeout_a: assert property (
        q.mode == swhd_pkg::SWHD_LIGHT && !host_cmd && !gpio_hit && tmr_done
        && !cmd.periodic_en |=> q.mode == swhd_pkg::SWHD_ACTIVE && q.cause[`SWHD_C_TMR])
        else $error("light timeout did not wake");

    standby_wake_a: assert property (
        q.mode == swhd_pkg::SWHD_LIGHT && !host_cmd && !gpio_hit && tmr_done
        && cmd.periodic_en |=> q.mode == swhd_pkg::SWHD_LSERVE && stat.hf_clk_en)
        else $error("standby did not wake itself");

    // Packet detection only when no bus power is seen
    spi_detect_a: assert property (
        !q.host_if_valid && q.mode == swhd_pkg::SWHD_ACTIVE && !q.sync2[`SWHD_S_VBUS]
        && !sdio_pkt && spi_pkt
        |=> q.host_if_valid && q.host_if == swhd_pkg::SWHD_IF_SPI)
        else $error("spi host not detected");

    usb_detect_a: assert property (
        !q.host_if_valid && q.mode == swhd_pkg::SWHD_ACTIVE && q.sync2[`SWHD_S_VBUS]
        |=> q.host_if_valid && q.host_if == ($past(q.sync2[`SWHD_S_FLAV])
            ? swhd_pkg::SWHD_IF_USB : swhd_pkg::SWHD_IF_USB_CDC))
        else $error("usb host flavour wrong");

    // Raw pins alone never move the sleep state
    deep_sync_a: assert property (
        q.mode == swhd_pkg::SWHD_DEEP && !q.sync2[`SWHD_S_COMP] && !q.sync2[`SWHD_S_RTC]
        && !q.sync2[`SWHD_S_WDT] && !gpio_hit && !tmr_done
        |=> q.mode == swhd_pkg::SWHD_DEEP)
        else $error("unsynchronised wake");

    wake_all_a: assert property (
        q.mode == swhd_pkg::SWHD_DEEP && q.sync2[`SWHD_S_COMP] && q.sync2[`SWHD_S_RTC]
        |=> q.mode == swhd_pkg::SWHD_ACTIVE && q.cause[`SWHD_C_COMP] && q.cause[`SWHD_C_RTC])
        else $error("simultaneous wake causes not all recorded");

    cov_deep_wake_c: cover property (
        q.mode == swhd_pkg::SWHD_DEEP ##1 q.mode == swhd_pkg::SWHD_ACTIVE);
    cov_light_serve_c: cover property (
        q.mode == swhd_pkg::SWHD_LSERVE ##[1:20] q.mode == swhd_pkg::SWHD_LIGHT);
    cov_usb_refuse_c: cover property (stat.deep_refused);
    cov_periodic_c: cover property (
        q.mode == swhd_pkg::SWHD_LIGHT && tmr_done && cmd.periodic_en && !host_cmd
        && !gpio_hit);

endmodule : swhd_sleep_ctrl

// ### tb/swhd_host_model.sv
// Host processor model on the far side of the host interface
module swhd_host_model (
    input  wire logic clk,
    output logic      host_cmd,
    output logic      host_op_done,
    output logic      sdio_pkt,
    output logic      spi_pkt
);
    timeunit 1ns;
    timeprecision 1ps;

    // Attention line stays masked until an SPI link is set up again
    logic irq_en = 1'h0;

    // Lines idle low between transfers
    initial {host_cmd, host_op_done, sdio_pkt, spi_pkt} = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Open a packet exchange so the device can find the link
    task automatic pkt(input logic spi);
        @(posedge clk);
        if (spi) spi_pkt <= 1'h1;
        else sdio_pkt <= 1'h1;
        @(posedge clk);
        {spi_pkt, sdio_pkt} <= 2'h0;
        irq_en <= spi;
    endtask : pkt

    // Mask the attention line before deep sleep
    task automatic irq_mask();
        irq_en = 1'h0;
    endtask : irq_mask

    // One-cycle command strobe, no wake sequence first
    task automatic cmd_start();
        @(posedge clk);
        host_cmd <= 1'h1;
        @(posedge clk);
        host_cmd <= 1'h0;
    endtask : cmd_start

    // Operation ends after n cycles of service
    task automatic cmd_done(input int n);
        repeat (n) @(posedge clk);
        host_op_done <= 1'h1;
        @(posedge clk);
        host_op_done <= 1'h0;
    endtask : cmd_done
endmodule : swhd_host_model

// ### tb/swhd_sleep_ctrl_tb_top.sv
// Self-checking bench for the sleep, wake and host-detect controller
`include "swhd_defines.svh"
module swhd_sleep_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam swhd_pkg::swhd_mode_type m_act = swhd_pkg::SWHD_ACTIVE;
    localparam swhd_pkg::swhd_mode_type m_lit = swhd_pkg::SWHD_LIGHT;
    localparam swhd_pkg::swhd_mode_type m_srv = swhd_pkg::SWHD_LSERVE;
    localparam swhd_pkg::swhd_mode_type m_dp  = swhd_pkg::SWHD_DEEP;
    logic                   clk        = 1'h0;
    logic                   nrst       = 1'h0;
    logic                   uart_det   = 1'h0;
    logic [3:0]             blk_busy   = 4'h0;
    logic [6:0]             pins       = 7'h20; // Lanes as the sync map; plain USB
    logic                   host_cmd, host_op_done, sdio_pkt, spi_pkt;
    swhd_pkg::swhd_cmd_type cmd        = '{gpio_pol: 1'h1, timeout: 16'hffff, default: '0};
    swhd_pkg::swhd_stat_type stat;
    int                     num_errors = 0;
    int                     n_compared = 0;

    ////////////////////////////////////////////////////////////////////////
    // Design, host model and clock
    swhd_sleep_ctrl u_dut (
        .clk(clk), .nrst(nrst), .cmd(cmd), .host_cmd(host_cmd),
        .host_op_done(host_op_done), .sdio_pkt(sdio_pkt), .spi_pkt(spi_pkt),
        .uart_sw_detect(uart_det), .blk_busy(blk_busy),
        .wake_gpio_pin(pins[`SWHD_S_GPIO]), .comparator_evt(pins[`SWHD_S_COMP]),
        .rtc_timeout_evt(pins[`SWHD_S_RTC]), .wdt_irq(pins[`SWHD_S_WDT]),
        .vbus_pin(pins[`SWHD_S_VBUS]), .usb_flavour_select_pin(pins[`SWHD_S_FLAV]),
        .lf_clk_pin(pins[`SWHD_S_LF]), .stat(stat));
    swhd_host_model u_host (.clk(clk), .host_cmd(host_cmd), .host_op_done(host_op_done),
        .sdio_pkt(sdio_pkt), .spi_pkt(spi_pkt));
    initial forever #12.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // Compare, verdict and small helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic cm(input swhd_pkg::swhd_mode_type m);
        chk(32'(stat.mode), 32'(m));
    endtask : cm
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tk
    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'h0;
        repeat (12) @(posedge clk);
        nrst <= 1'h1;
        tk(1);
    endtask : do_reset
    // One slow-clock period of two cycles high, three low
    task automatic lf_pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            pins[`SWHD_S_LF] <= 1'h1;
            repeat (2) @(posedge clk);
            pins[`SWHD_S_LF] <= 1'h0;
            tk(2);
        end
    endtask : lf_pulse
    task automatic wait_mode(input swhd_pkg::swhd_mode_type m);
        for (int k = 0; k < 12 && stat.mode !== m; k++) tk(1);
        cm(m);
    endtask : wait_mode
    task automatic req(input logic deep);
        @(posedge clk);
        if (deep) cmd.deep_req <= 1'h1;
        else cmd.light_req <= 1'h1;
        @(posedge clk);
        {cmd.deep_req, cmd.light_req} <= 2'h0;
        #1;
    endtask : req
    task automatic clr_cause();
        tk(3);
        cmd.cause_clr <= 6'h3f;
        @(posedge clk);
        cmd.cause_clr <= 6'h00;
        tk(1);
        chk(32'(stat.wake_cause), 32'h0);
    endtask : clr_cause
    task automatic enter_deep();
        u_host.irq_mask();
        req(1'h1);
        cm(m_dp);
        chk(32'({stat.hf_clk_en, stat.subsys_run, stat.host_ready}), 32'h0);
        chk(32'(stat.ram_retain_en), 32'(cmd.ram_retain));
    endtask : enter_deep

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_detect();
        swhd_pkg::swhd_stat_type e;
        e = '{mode: m_act, hf_clk_en: 1'h1, subsys_run: 1'h1, host_ready: 1'h1,
              host_if: swhd_pkg::SWHD_IF_NONE, default: '0};
        chk(32'(stat), 32'(e));
        u_host.pkt(1'h1);
        tk(1);
        chk(32'({stat.host_if, stat.host_if_valid}), {28'h0, 3'h2, 1'h1});
        u_host.pkt(1'h0);
        tk(1);
        chk(32'(stat.host_if), 32'(swhd_pkg::SWHD_IF_SPI));
        @(posedge clk);
        blk_busy <= 4'ha;
        tk(1);
        chk(32'(stat.blk_clk_en), 32'ha);
    endtask : t_reset_detect
    task automatic t_deep_timer();
        cmd.timeout <= 16'h0003;
        cmd.ram_retain <= 1'h1;
        enter_deep();
        lf_pulse(2);
        cm(m_dp);
        lf_pulse(1);
        wait_mode(m_act);
        chk(32'({stat.wake_cause, stat.ram_retain_en}), 32'h2);
        chk(32'(stat.host_if), 32'(swhd_pkg::SWHD_IF_SPI));
        cmd.timeout <= 16'hffff;
        clr_cause();
    endtask : t_deep_timer
    task automatic t_deep_src();
        logic [6:0] msk [6] = '{7'h01, 7'h01, 7'h02, 7'h04, 7'h08, 7'h06};
        logic [5:0] cse [6] = '{6'h02, 6'h02, 6'h04, 6'h08, 6'h10, 6'h0c};
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            cmd.gpio_pol <= (i != 1);
            pins[`SWHD_S_GPIO] <= (i == 1);
            cmd.ram_retain <= i[0];
            tk(3);
            enter_deep();
            @(posedge clk);
            pins <= pins ^ msk[i];
            tk(2);
            cm(m_dp);
            tk(1);
            cm(m_act);
            chk(32'(stat.wake_cause), 32'(cse[i]));
            pins <= pins ^ msk[i];
            clr_cause();
        end
    endtask : t_deep_src
    task automatic t_light();
        req(1'h0);
        cm(m_lit);
        chk(32'({stat.hf_clk_en, stat.host_ready, stat.blk_clk_en}), 32'h10);
        u_host.cmd_start();
        #1;
        cm(m_srv);
        chk(32'({stat.hf_clk_en, stat.wake_cause}), 32'h60);
        u_host.cmd_done(3);
        #1;
        cm(m_lit);
        chk(32'(stat.hf_clk_en), 32'h0);
        @(posedge clk);
        pins[`SWHD_S_GPIO] <= 1'h1;
        tk(3);
        cm(m_act);
        chk(32'(stat.wake_cause), 32'h22);
        pins[`SWHD_S_GPIO] <= 1'h0;
        clr_cause();
        cmd.periodic_en <= 1'h1;
        cmd.timeout <= 16'h0002;
        req(1'h0);
        lf_pulse(2);
        wait_mode(m_srv);
        u_host.cmd_done(1);
        cmd.periodic_en <= 1'h0;
        #1;
        cm(m_lit);
        lf_pulse(2);
        wait_mode(m_act);
        chk(32'(stat.wake_cause), 32'h01);
    endtask : t_light
    task automatic t_usb();
        for (int f = 0; f < 2; f++) begin
            pins[`SWHD_S_FLAV] <= (f == 0);
            pins[`SWHD_S_VBUS] <= 1'h1;
            do_reset();
            tk(4);
            chk(32'(stat.host_if), 32'(f ? 3'h5 : 3'h4));
            req(1'h1);
            chk(32'({stat.mode, stat.deep_refused}), 32'h1);
            tk(1);
            chk(32'(stat.deep_refused), 32'h0);
        end
    endtask : t_usb
    task automatic t_detect_alt();
        pins[`SWHD_S_VBUS] <= 1'h0;
        do_reset();
        u_host.pkt(1'h0);
        tk(1);
        chk(32'(stat.host_if), 32'h1);
        do_reset();
        @(posedge clk);
        uart_det <= 1'h1;
        @(posedge clk);
        uart_det <= 1'h0;
        tk(1);
        chk(32'({stat.host_if, stat.host_if_valid}), 32'h7);
    endtask : t_detect_alt

    ////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        do_reset();
        t_reset_detect();
        t_deep_timer();
        t_deep_src();
        t_light();
        t_usb();
        t_detect_alt();
        end_of_test();
    end
    initial begin
        #100us;
        num_errors++;
        end_of_test();
    end
endmodule : swhd_sleep_ctrl_tb_top
